// ### logic/ccr_regs.sv
/*
  ccr_regs: per-channel configuration and status registers of a
  four-channel voice codec, written and read through byte commands.
  Assumes the host port bytes come from logic on mclk_i, the channel
  enable bits come from a register on the same clock, and the line
  pins and detect bits arrive asynchronously.
*/
// Behaviour
// - five line pins per channel: direction 1 output, 0 input, reset inputs
// - command bit 0 chooses write (0) or read (1) of following bytes
// - operating functions: 60h write, 61h read, one byte
// - coding bit 0 compressed, 1 linear; law bit 0 A-law, 1 mu-law
// - each filter enable bit: 0 default coefficients, 1 programmed
// - defaults live in fixed storage apart from writable coefficients
// - eight-bit detect mask, 6Ch write, 6Dh read
// - masked detect change never pulls interrupt low; all masked at reset
// - mask access and revision read ignore channel enables
// - transmit cutoff bit (70h/71h) 1 disconnects transmit path
// - receive cutoff cuts receive path and disables balance filter
// - high-pass bit 1 bypasses transmit high-pass, 0 applies it
// - lower receive gain bit 1 inserts extra receive loss
// - arm bit 1 arms transmit interrupt
// - interface loopback bit 1 enables slot-assigner loopback
// - full loopback bit 1 enables full digital loopback, reset 0
// - tone bit 1 injects receive test tone; conditions reset to 00h
// - 73h returns an eight-bit revision code, no read/write bit
// - gain sign field 0 means plus one, 1 means minus one
// - transmit gain 80h/81h, two bytes, reset A9F0h
// - receive gain 82h/83h, two bytes, reset 23A1h
// - disabled channels ignore channel-dependent commands
// - detect bits are two-flop synchronized inputs passed out unmasked; the mask gates only the interrupt
`timescale 1ns/1ns

module ccr_regs #(
  parameter int        NCH      = 4,
  parameter int        NPIN     = 5,
  parameter logic [7:0] REV_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              byte_valid_i,
  input  wire logic              byte_first_i,
  input  wire logic [7:0]        byte_i,
  output logic      [7:0]        rd_byte_o,
  output logic                   rd_valid_o,
  input  wire logic [NCH-1:0]    chan_en_i,
  input  wire logic [NCH-1:0]    chan_active_i,
  input  wire logic              clk_fail_i,
  input  wire logic [2*NCH-1:0]  detect_bit_i,
  input  wire logic              irq_clear_i,
  output logic                   irq_n_o,
  output logic [2*NCH-1:0]       detect_bit_o,
  input  wire logic [NCH*NPIN-1:0] line_io_i,
  input  wire logic [NCH*NPIN-1:0] line_out_i,
  output logic [NCH*NPIN-1:0]    line_io_o,
  output logic [NCH*NPIN-1:0]    line_io_oe_o,
  output logic [NCH*NPIN-1:0]    line_in_o,
  output logic [NCH-1:0]         linear_code_o,
  output logic [NCH-1:0]         mu_law_o,
  output logic [NCH*6-1:0]       filter_prog_o,
  output logic [NCH-1:0]         tx_cutoff_o,
  output logic [NCH-1:0]         rx_cutoff_o,
  output logic [NCH-1:0]         balance_off_o,
  output logic [NCH-1:0]         highpass_bypass_o,
  output logic [NCH-1:0]         rx_loss_insert_o,
  output logic [NCH-1:0]         tx_irq_arm_o,
  output logic [NCH-1:0]         interface_loopback_o,
  output logic [NCH-1:0]         full_loopback_o,
  output logic [NCH-1:0]         test_tone_on_o,
  output logic [NCH*16-1:0]      tx_gain_coef_o,
  output logic [NCH*16-1:0]      rx_gain_coef_o
);

  // command decode targets
  typedef enum logic [2:0] {
    CCR_OP_NONE, CCR_OP_DIR, CCR_OP_FUNC, CCR_OP_MASK,
    CCR_OP_COND, CCR_OP_REV, CCR_OP_TXG, CCR_OP_RXG
  } ccr_op_t;

  ccr_pkg::ccr_state_t state_ff;
  ccr_pkg::ccr_state_t nxt_state;
  ccr_op_t             op_ff;
  ccr_op_t             nxt_op;
  logic                read_ff;
  logic [7:0]          hold_ff;
  logic [7:0]          mask_ff;
  logic [2*NCH-1:0]    det_meta_ff;
  logic [2*NCH-1:0]    det_sync_ff;
  logic [2*NCH-1:0]    det_prev_ff;
  logic [2*NCH-1:0]    pend_ff;
  logic [NCH*NPIN-1:0] pin_meta_ff;
  logic [NCH*NPIN-1:0] pin_sync_ff;
  logic [NPIN-1:0]     dir_ff  [NCH];
  logic [7:0]          func_ff [NCH];
  logic [7:0]          cond_ff [NCH];
  logic [15:0]         txg_ff  [NCH];
  logic [15:0]         rxg_ff  [NCH];
  logic                data_strobe;
  logic                wr_fire;
  logic [1:0]          rd_ch;
  logic [7:0]          nxt_rd_byte;

  // a data byte is any strobe that is not a command byte
  assign data_strobe = byte_valid_i & ~byte_first_i;
  // single-byte registers commit on byte one, gains on byte two
  assign wr_fire = data_strobe & ~read_ff &
                   ((state_ff == ccr_pkg::CCR_BYTE2) |
                    (state_ff == ccr_pkg::CCR_BYTE1 &&
                     op_ff != CCR_OP_TXG && op_ff != CCR_OP_RXG));

  // command byte decode; bit 0 ignored when matching a pair
  always_comb begin
    nxt_op = CCR_OP_NONE;
    unique case ({byte_i[7:1], 1'b0})
      ccr_pkg::CMD_PIN_DIR:  nxt_op = CCR_OP_DIR;
      ccr_pkg::CMD_OP_FUNC:  nxt_op = CCR_OP_FUNC;
      ccr_pkg::CMD_IRQ_MASK: nxt_op = CCR_OP_MASK;
      ccr_pkg::CMD_OP_COND:  nxt_op = CCR_OP_COND;
      ccr_pkg::CMD_TX_GAIN:  nxt_op = CCR_OP_TXG;
      ccr_pkg::CMD_RX_GAIN:  nxt_op = CCR_OP_RXG;
      default:               nxt_op = CCR_OP_NONE;
    endcase
    // revision is one exact code, not a pair
    if (byte_i == ccr_pkg::CMD_REVISION) begin
      nxt_op = CCR_OP_REV;
    end else if ({byte_i[7:1], 1'b0} == ccr_pkg::CMD_REVISION &&
                 byte_i[ccr_pkg::RW_BIT] == 1'b0) begin
      nxt_op = CCR_OP_NONE;
    end
  end

  // sequencer: a command byte always restarts, so a lost byte heals
  always_comb begin
    nxt_state = state_ff;
    if (byte_valid_i && byte_first_i) begin
      nxt_state = (nxt_op == CCR_OP_NONE) ? ccr_pkg::CCR_IDLE
                                          : ccr_pkg::CCR_BYTE1;
    end else if (data_strobe) begin
      unique case (state_ff)
        ccr_pkg::CCR_IDLE:  nxt_state = ccr_pkg::CCR_IDLE;
        ccr_pkg::CCR_BYTE1: nxt_state =
          (op_ff == CCR_OP_TXG || op_ff == CCR_OP_RXG) ?
          ccr_pkg::CCR_BYTE2 : ccr_pkg::CCR_IDLE;
        ccr_pkg::CCR_BYTE2: nxt_state = ccr_pkg::CCR_IDLE;
        default:            nxt_state = ccr_pkg::CCR_IDLE;
      endcase
    end
  end

  // sequencer state and latched command
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ccr_pkg::CCR_IDLE;
      op_ff    <= CCR_OP_NONE;
      read_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (byte_valid_i && byte_first_i) begin
        op_ff   <= nxt_op;
        read_ff <= byte_i[ccr_pkg::RW_BIT];
      end
    end
  end

  // first gain byte waits here so a gain word changes in one step
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_ff <= 8'h00;
    end else if (data_strobe && state_ff == ccr_pkg::CCR_BYTE1) begin
      hold_ff <= byte_i;
    end
  end

  // lowest enabled channel answers reads; with none enabled, channel-dependent reads are zero
  always_comb begin
    rd_ch = 2'd0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (chan_en_i[i]) begin
        rd_ch = i[1:0];
      end
    end
  end

  // read data for the byte now being transferred
  always_comb begin
    nxt_rd_byte = 8'h00;
    unique case (op_ff)
      CCR_OP_MASK: nxt_rd_byte = mask_ff;
      CCR_OP_REV:  nxt_rd_byte = REV_CODE;
      CCR_OP_DIR:  nxt_rd_byte = {1'b0, chan_active_i[rd_ch], clk_fail_i,
                                  dir_ff[rd_ch]};
      CCR_OP_FUNC: nxt_rd_byte = func_ff[rd_ch];
      CCR_OP_COND: nxt_rd_byte = cond_ff[rd_ch];
      CCR_OP_TXG:  nxt_rd_byte = (state_ff == ccr_pkg::CCR_BYTE1) ?
                                 txg_ff[rd_ch][15:8] : txg_ff[rd_ch][7:0];
      CCR_OP_RXG:  nxt_rd_byte = (state_ff == ccr_pkg::CCR_BYTE1) ?
                                 rxg_ff[rd_ch][15:8] : rxg_ff[rd_ch][7:0];
      default:     nxt_rd_byte = 8'h00;
    endcase
    // channel-dependent reads need some channel enabled
    if (op_ff != CCR_OP_MASK && op_ff != CCR_OP_REV && chan_en_i == '0) begin
      nxt_rd_byte = 8'h00;
    end
  end

  // read answer one cycle after each data strobe of a read command
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_byte_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= data_strobe & read_ff &
                    (state_ff != ccr_pkg::CCR_IDLE);
      if (data_strobe && read_ff && state_ff != ccr_pkg::CCR_IDLE) begin
        rd_byte_o <= nxt_rd_byte;
      end
    end
  end

  // detect mask is global, never gated by channel enables
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_ff <= ccr_pkg::RST_IRQ_MASK;
    end else if (wr_fire && op_ff == CCR_OP_MASK) begin
      mask_ff <= byte_i;
    end
  end

  // detect inputs are asynchronous: two flops before any use
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      det_meta_ff <= '0;
      det_sync_ff <= '0;
      det_prev_ff <= '0;
    end else begin
      det_meta_ff <= detect_bit_i;
      det_sync_ff <= det_meta_ff;
      det_prev_ff <= det_sync_ff;
    end
  end

  // unmasked changes latch; a new change beats a same-cycle clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_ff      <= '0;
      irq_n_o      <= 1'b1;
      detect_bit_o <= '0;  // keeps reset from acting as a data enable
    end else begin
      pend_ff <= ((irq_clear_i ? '0 : pend_ff) |
                  ((det_sync_ff ^ det_prev_ff) & ~mask_ff));
      irq_n_o <= ~|(pend_ff & ~mask_ff);
      detect_bit_o <= det_sync_ff;
    end
  end

  // line pins are asynchronous as well
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= line_io_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // per-channel storage and decoded controls
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic wr_ch;

    // writes land only in enabled channels
    assign wr_ch = wr_fire & chan_en_i[c];

    // configuration registers of this channel
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        dir_ff[c]  <= ccr_pkg::RST_PIN_DIR;
        func_ff[c] <= ccr_pkg::RST_OP_FUNC;
        cond_ff[c] <= ccr_pkg::RST_OP_COND;
        txg_ff[c]  <= ccr_pkg::RST_TX_GAIN;
        rxg_ff[c]  <= ccr_pkg::RST_RX_GAIN;
      end else if (wr_ch) begin
        unique case (op_ff)
          CCR_OP_DIR:  dir_ff[c]  <= byte_i[NPIN-1:0];
          CCR_OP_FUNC: func_ff[c] <= byte_i;
          CCR_OP_COND: cond_ff[c] <= byte_i;
          CCR_OP_TXG:  txg_ff[c]  <= {hold_ff, byte_i};
          CCR_OP_RXG:  rxg_ff[c]  <= {hold_ff, byte_i};
          default:     ;
        endcase
      end
    end

    // registered outputs; defaults come from constants, never the rams
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        line_io_oe_o[c*NPIN +: NPIN]  <= '0;
        line_io_o[c*NPIN +: NPIN]     <= '0;
        line_in_o[c*NPIN +: NPIN]     <= '0;
        linear_code_o[c]              <= 1'b0;
        mu_law_o[c]                   <= 1'b0;
        filter_prog_o[c*6 +: 6]       <= '0;
        tx_cutoff_o[c]                <= 1'b0;
        rx_cutoff_o[c]                <= 1'b0;
        balance_off_o[c]              <= 1'b0;
        highpass_bypass_o[c]          <= 1'b0;
        rx_loss_insert_o[c]           <= 1'b0;
        tx_irq_arm_o[c]               <= 1'b0;
        interface_loopback_o[c]       <= 1'b0;
        full_loopback_o[c]            <= 1'b0;
        test_tone_on_o[c]             <= 1'b0;
        tx_gain_coef_o[c*16 +: 16]    <= ccr_pkg::ROM_TX_GAIN;
        rx_gain_coef_o[c*16 +: 16]    <= ccr_pkg::ROM_RX_GAIN;
      end else begin
        line_io_oe_o[c*NPIN +: NPIN]  <= dir_ff[c];
        line_io_o[c*NPIN +: NPIN]     <= line_out_i[c*NPIN +: NPIN];
        line_in_o[c*NPIN +: NPIN]     <= pin_sync_ff[c*NPIN +: NPIN];
        linear_code_o[c]   <= func_ff[c][ccr_pkg::F_LINEAR];
        // law only matters while compressed coding is chosen
        mu_law_o[c]        <= ~func_ff[c][ccr_pkg::F_LINEAR] &
                              func_ff[c][ccr_pkg::F_MU_LAW];
        filter_prog_o[c*6 +: 6] <= func_ff[c][5:0];
        tx_cutoff_o[c]     <= cond_ff[c][ccr_pkg::C_TX_CUT];
        rx_cutoff_o[c]     <= cond_ff[c][ccr_pkg::C_RX_CUT];
        balance_off_o[c]   <= cond_ff[c][ccr_pkg::C_RX_CUT];
        highpass_bypass_o[c] <= cond_ff[c][ccr_pkg::C_HP_BYP];
        rx_loss_insert_o[c]  <= cond_ff[c][ccr_pkg::C_RX_LOSS];
        tx_irq_arm_o[c]      <= cond_ff[c][ccr_pkg::C_TX_ARM];
        interface_loopback_o[c] <= cond_ff[c][ccr_pkg::C_IF_LOOP];
        full_loopback_o[c]   <= cond_ff[c][ccr_pkg::C_FULL_LP];
        test_tone_on_o[c]    <= cond_ff[c][ccr_pkg::C_TONE];
        // sign bits pass unchanged; the datapath reads 1 as minus one
        tx_gain_coef_o[c*16 +: 16] <=
          func_ff[c][ccr_pkg::F_TX_GAIN] ? txg_ff[c]
                                         : ccr_pkg::ROM_TX_GAIN;
        rx_gain_coef_o[c*16 +: 16] <=
          func_ff[c][ccr_pkg::F_RX_GAIN] ? rxg_ff[c]
                                         : ccr_pkg::ROM_RX_GAIN;
      end
    end
  end

endmodule // ccr_regs

// ### inc/ccr_pkg.sv
/*
  ccr_pkg: command codes, field positions, reset values and fixed
  default coefficients of the codec channel configuration registers.
  Assumes a byte-wide host command port and four voice channels.
*/
package ccr_pkg;

  // command codes, bit 0 is the read/write select (0 write, 1 read) except in the 73h revision code
  localparam logic [7:0] CMD_PIN_DIR    = 8'h54;
  localparam logic [7:0] CMD_OP_FUNC    = 8'h60;
  localparam logic [7:0] CMD_IRQ_MASK   = 8'h6C;
  localparam logic [7:0] CMD_OP_COND    = 8'h70;
  localparam logic [7:0] CMD_REVISION   = 8'h73;
  localparam logic [7:0] CMD_TX_GAIN    = 8'h80;
  localparam logic [7:0] CMD_RX_GAIN    = 8'h82;
  localparam int         RW_BIT         = 0;

  // reset values
  localparam logic [4:0]  RST_PIN_DIR   = 5'h00;
  localparam logic [7:0]  RST_OP_FUNC   = 8'h00;
  localparam logic [7:0]  RST_IRQ_MASK  = 8'hFF;
  localparam logic [7:0]  RST_OP_COND   = 8'h00;
  localparam logic [15:0] RST_TX_GAIN   = 16'hA9F0;
  localparam logic [15:0] RST_RX_GAIN   = 16'h23A1;

  // fixed defaults, never touched by coefficient writes
  localparam logic [15:0] ROM_TX_GAIN   = 16'hA9F0;
  localparam logic [15:0] ROM_RX_GAIN   = 16'h23A1;

  // operating functions fields
  localparam int F_LINEAR   = 7;
  localparam int F_MU_LAW   = 6;
  localparam int F_RX_GAIN  = 5;
  localparam int F_TX_GAIN  = 4;
  localparam int F_X        = 3;
  localparam int F_R        = 2;
  localparam int F_IMP      = 1;
  localparam int F_BAL      = 0;

  // operating conditions fields
  localparam int C_TX_CUT   = 7;
  localparam int C_RX_CUT   = 6;
  localparam int C_HP_BYP   = 5;
  localparam int C_RX_LOSS  = 4;
  localparam int C_TX_ARM   = 3;
  localparam int C_IF_LOOP  = 2;
  localparam int C_FULL_LP  = 1;
  localparam int C_TONE     = 0;

  // sign bits inside a gain word (1 means a factor of minus one)
  localparam int G_SIGN4    = 15;
  localparam int G_SIGN3    = 11;
  localparam int G_SIGN2    = 7;
  localparam int G_SIGN1    = 3;

  // command sequencer, gray along idle -> byte1 -> byte2
  typedef enum logic [1:0] {
    CCR_IDLE  = 2'b00,
    CCR_BYTE1 = 2'b01,
    CCR_BYTE2 = 2'b11
  } ccr_state_t;

endpackage

// ### dv/ccr_host_model.sv
/*
  ccr_host_model: host side of the byte command port. It sends a
  command byte and then its data bytes, and it collects read answers.
  Assumes the device answers one cycle after each data byte.
*/
`timescale 1ns/1ns

module ccr_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rd_byte_o,
  input  wire logic       rd_valid_o,
  output logic            byte_valid_i,
  output logic            byte_first_i,
  output logic [7:0]      byte_i
);

  // idle port at time zero
  initial begin
    byte_valid_i = 1'b0;
    byte_first_i = 1'b0;
    byte_i       = 8'hC3;
  end

  // one strobe, held across exactly one rising edge
  task automatic put(input logic f, input logic [7:0] b);
    byte_valid_i = 1'b1;
    byte_first_i = f;
    byte_i       = b;
    @(posedge mclk_i);
    #1;
  endtask

  // command byte first, then data bytes high byte first
  // bit 0 of the command picks write or read
  task automatic xfer(input logic [7:0] cmd, input int n, input int gap,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output int nrd);
    rd  = 16'h0000;
    nrd = 0;
    put(1'b1, cmd);
    for (int i = n - 1; i >= 0; i--) begin
      put(1'b0, wd[i*8+:8]);
      if (rd_valid_o === 1'b1) begin
        rd  = {rd[7:0], rd_byte_o};
        nrd = nrd + 1;
      end
      // slow host: idle cycles, byte lines scrambled so no stale value
      for (int j = 0; j < gap; j++) begin
        byte_valid_i = 1'b0;
        byte_i       = ~byte_i;
        @(posedge mclk_i);
        #1;
      end
    end
    byte_valid_i = 1'b0;
    byte_i       = ~byte_i;
    // one idle edge, so a following call never re-raises the strobe
    // in the same time step that lowered it
    @(posedge mclk_i);
    #1;
  endtask

endmodule // ccr_host_model

// ### dv/ccr_regs_asserts.sv
/*
  ccr_regs_chk: concurrent checks on the ports of ccr_regs.
  Assumes one clock, mclk_i, and the asynchronous high reset rst_i.
*/
`timescale 1ns/1ns

module ccr_regs_chk #(
  parameter int         NCH      = 4,
  parameter int         NPIN     = 5,
  parameter logic [7:0] REV_CODE = 8'h5A
) (
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire logic                byte_valid_i,
  input wire logic                byte_first_i,
  input wire logic [7:0]          byte_i,
  input wire logic [7:0]          rd_byte_o,
  input wire logic                rd_valid_o,
  input wire logic                irq_n_o,
  input wire logic [2*NCH-1:0]    detect_bit_o,
  input wire logic [NCH*NPIN-1:0] line_io_oe_o,
  input wire logic [NCH-1:0]      linear_code_o,
  input wire logic [NCH-1:0]      mu_law_o,
  input wire logic [NCH-1:0]      rx_cutoff_o,
  input wire logic [NCH-1:0]      balance_off_o,
  input wire logic [NCH*6-1:0]    filter_prog_o,
  input wire logic [NCH*16-1:0]   tx_gain_coef_o,
  input wire logic [NCH*16-1:0]   rx_gain_coef_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic [3:0]       quiet_ff;
  logic [2*NCH-1:0] det_ff;

  // cycles since a detect change or host byte, saturating at 15
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_ff <= 4'hF;
      det_ff   <= '0;
    end else begin
      det_ff <= detect_bit_o;
      if (byte_valid_i || det_ff != detect_bit_o) quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
    end
  end

  sequence wr_cmd_s;
    byte_valid_i && byte_first_i && !byte_i[0];
  endsequence
  sequence data_s;
    byte_valid_i && !byte_first_i;
  endsequence
  sequence rev_cmd_s;
    byte_valid_i && byte_first_i && byte_i == 8'h73;
  endsequence

  write_no_answer_a: assert property (
    wr_cmd_s ##1 data_s |=> !rd_valid_o) else $error("answer to a write");
  answer_cause_a: assert property (
    rd_valid_o |-> $past(byte_valid_i && !byte_first_i))
    else $error("answer without a data byte");
  revision_read_a: assert property (
    rev_cmd_s ##1 data_s |=> rd_valid_o && rd_byte_o == REV_CODE)
    else $error("revision code wrong");
  dir_change_a: assert property (
    line_io_oe_o != $past(line_io_oe_o) |-> $past(byte_valid_i, 2))
    else $error("pin direction moved without a write");
  law_linear_a: assert property (
    (linear_code_o & mu_law_o) == {NCH{1'b0}})
    else $error("law select active in linear mode");
  balance_cut_a: assert property (
    (rx_cutoff_o & ~balance_off_o) == {NCH{1'b0}})
    else $error("balance filter on during receive cutoff");
  tx_default_a: assert property (
    !filter_prog_o[4] |-> tx_gain_coef_o[15:0] == ccr_pkg::ROM_TX_GAIN)
    else $error("transmit gain not default");
  rx_default_a: assert property (
    !filter_prog_o[5] |-> rx_gain_coef_o[15:0] == ccr_pkg::ROM_RX_GAIN)
    else $error("receive gain not default");
  irq_cause_a: assert property (
    $fell(irq_n_o) |-> quiet_ff < 4'h4)
    else $error("interrupt with no cause");
endmodule // ccr_regs_chk

bind ccr_regs ccr_regs_chk #(.NCH(NCH), .NPIN(NPIN), .REV_CODE(REV_CODE))
  ccr_regs_chk_i (.mclk_i(mclk_i), .rst_i(rst_i),
  .byte_valid_i(byte_valid_i), .byte_first_i(byte_first_i),
  .byte_i(byte_i), .rd_byte_o(rd_byte_o), .rd_valid_o(rd_valid_o),
  .irq_n_o(irq_n_o), .detect_bit_o(detect_bit_o),
  .line_io_oe_o(line_io_oe_o), .linear_code_o(linear_code_o),
  .mu_law_o(mu_law_o), .rx_cutoff_o(rx_cutoff_o),
  .balance_off_o(balance_off_o), .filter_prog_o(filter_prog_o),
  .tx_gain_coef_o(tx_gain_coef_o), .rx_gain_coef_o(rx_gain_coef_o));

// ### dv/tb_top.sv
/*
  tb_top: self-checking bench for ccr_regs with a host command model.
  Assumes a 20 MHz clock and answers one cycle after each data byte.
*/
`timescale 1ns/1ns

module tb_top;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  logic        mclk_i = 1'b0, rst_i = 1'b1, clk_fail_i = 1'b1;
  logic        irq_clear_i = 1'b0, bv, bf, rv, irq_n;
  logic [7:0]  bt, rb, det_o, detect_bit_i = 8'h00;
  logic [3:0]  chan_en_i = 4'hF, chan_active_i = 4'h1;
  logic [19:0] line_io_i = 20'hA5A5A, line_out_i = 20'h3C3C3;
  logic [19:0] pin_o, oe, pin_in;
  logic [3:0]  lin, mu, txc, rxc, bal, hpb, rxl, arm, ifl, ful, test_tone_on;
  logic [23:0] fprog;
  logic [63:0] txg, rxg;
  int          err_count = 0, check_count = 0;

  // free-running 20 MHz clock
  always #25 mclk_i = ~mclk_i;

  ccr_regs #(.REV_CODE(REV)) ccr_regs_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .byte_valid_i(bv), .byte_first_i(bf), .byte_i(bt), .rd_byte_o(rb),
    .rd_valid_o(rv), .chan_en_i(chan_en_i), .chan_active_i(chan_active_i),
    .clk_fail_i(clk_fail_i), .detect_bit_i(detect_bit_i),
    .irq_clear_i(irq_clear_i), .irq_n_o(irq_n), .detect_bit_o(det_o),
    .line_io_i(line_io_i), .line_out_i(line_out_i), .line_io_o(pin_o),
    .line_io_oe_o(oe), .line_in_o(pin_in), .linear_code_o(lin),
    .mu_law_o(mu), .filter_prog_o(fprog), .tx_cutoff_o(txc),
    .rx_cutoff_o(rxc), .balance_off_o(bal), .highpass_bypass_o(hpb),
    .rx_loss_insert_o(rxl), .tx_irq_arm_o(arm),
    .interface_loopback_o(ifl), .full_loopback_o(ful),
    .test_tone_on_o(test_tone_on), .tx_gain_coef_o(txg), .rx_gain_coef_o(rxg));

  ccr_host_model ccr_host_model_i (.mclk_i(mclk_i), .rd_byte_o(rb),
    .rd_valid_o(rv), .byte_valid_i(bv), .byte_first_i(bf), .byte_i(bt));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // writes go back to back, reads leave an idle cycle between bytes
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] w);
    logic [15:0] r;
    int          k;
    ccr_host_model_i.xfer(c, n, 0, w, r, k);
  endtask

  task automatic rd(input logic [7:0] c, input int n, input logic [15:0] e);
    logic [15:0] r;
    int          k;
    ccr_host_model_i.xfer(c, n, 1, 16'h5555, r, k);
    chk(k, n);
    chk(r, e);
  endtask

  function automatic logic [3:0] rep(input logic b);
    rep = {4{b}};
  endfunction

  task automatic t_reset;
    chk(oe, 0);
    chk(txg, {4{16'hA9F0}});
    chk(rxg, {4{16'h23A1}});
    chk(irq_n, 1'b1);
    rd(8'h61, 1, 16'h0000);
    rd(8'h6D, 1, 16'h00FF);
    rd(8'h71, 1, 16'h0000);
    rd(8'h81, 2, 16'hA9F0);
    rd(8'h83, 2, 16'h23A1);
    rd(8'h55, 1, 16'h0060);
    $display("test reset done");
  endtask

  task automatic t_dir;
    wr(8'h54, 1, 16'h0015);
    cyc(1);
    chk(oe, {4{5'h15}});
    chk(pin_o, line_out_i);
    cyc(3);
    chk(pin_in, line_io_i);
    rd(8'h55, 1, 16'h0075);
    $display("test direction done");
  endtask

  task automatic t_func;
    logic [7:0] v;
    for (int k = 0; k < 9; k++) begin
      v = (k < 8) ? (8'h01 << k) : 8'hC0;
      wr(8'h60, 1, {8'h00, v});
      cyc(1);
      chk(lin, rep(v[7]));
      chk(mu, rep(v[6] & ~v[7]));
      chk(fprog, {4{v[5:0]}});
      rd(8'h61, 1, {8'h00, v});
    end
    $display("test functions done");
  endtask

  task automatic t_cond;
    logic [7:0] v;
    for (int k = 0; k < 9; k++) begin
      v = (k < 8) ? (8'h01 << k) : 8'h00;
      wr(8'h70, 1, {8'h00, v});
      cyc(1);
      chk({txc, rxc, bal}, {rep(v[7]), rep(v[6]), rep(v[6])});
      chk({hpb,rxl,arm},{rep(v[5]),rep(v[4]),rep(v[3])});
      chk({ifl,ful,test_tone_on},{rep(v[2]),rep(v[1]),rep(v[0])});
      rd(8'h71, 1, {8'h00, v});
    end
    $display("test conditions done");
  endtask

  task automatic t_gain;
    wr(8'h60, 1, 16'h0000);
    wr(8'h80, 2, 16'h1234);
    wr(8'h82, 2, 16'h8F1E);
    cyc(1);
    chk(txg, {4{16'hA9F0}});
    rd(8'h81, 2, 16'h1234);
    wr(8'h80, 1, 16'h0077);
    rd(8'h81, 2, 16'h1234);
    wr(8'h60, 1, 16'h0030);
    cyc(1);
    chk(txg, {4{16'h1234}});
    chk(rxg, {4{16'h8F1E}});
    wr(8'h60, 1, 16'h0000);
    cyc(1);
    chk(rxg, {4{16'h23A1}});
    $display("test gains done");
  endtask

  task automatic t_chan;
    chan_en_i = 4'b0100;
    wr(8'h60, 1, 16'h0080);
    cyc(1);
    chk(lin, 4'b0100);
    rd(8'h61, 1, 16'h0080);
    chan_en_i = 4'h0;
    rd(8'h61, 1, 16'h0000);
    wr(8'h6C, 1, 16'h00F7);
    rd(8'h6D, 1, 16'h00F7);
    rd(8'h73, 1, {8'h00, REV});
    chan_en_i = 4'hF;
    $display("test channel enable done");
  endtask

  task automatic t_irq;
    int k;
    irq_clear_i = 1'b1;
    cyc(1);
    irq_clear_i = 1'b0;
    detect_bit_i = 8'h04;
    cyc(8);
    chk(irq_n, 1'b1);
    chk(det_o, 8'h04);
    detect_bit_i = 8'h0C;
    k = 0;
    while (irq_n !== 1'b0 && k < 10) begin
      cyc(1);
      k++;
    end
    chk(irq_n, 1'b0);
    if (irq_n !== 1'b0) give_verdict;
    irq_clear_i = 1'b1;
    cyc(1);
    irq_clear_i = 1'b0;
    cyc(3);
    chk(irq_n, 1'b1);
    $display("test interrupt done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence, with a second reset in mid-run
  initial begin
    cyc(16);
    rst_i = 1'b0;
    t_reset;
    t_dir;
    t_func;
    t_cond;
    t_gain;
    t_chan;
    t_irq;
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    t_reset;
    give_verdict;
  end
endmodule // tb_top
